// ==== abm_pkg.sv ====
/*
 Constants for the audio bus-master channel status block: register
 offsets within a channel, field positions, reset values, FIFO sizes.
 Assumes nothing of its surroundings.
*/
package abm_pkg;
  localparam int          CH_COUNT     = 3;
  localparam int          TX_CH        = 1;
  localparam logic [3:0]  OFF_CUR_IDX  = 4'h4;
  localparam logic [3:0]  OFF_LAST_IDX = 4'h5;
  localparam logic [3:0]  OFF_STATUS   = 4'h6;
  localparam logic [3:0]  OFF_DWORDS   = 4'h8;
  localparam int          IDX_W        = 5;
  localparam int          POS_W        = 16;
  localparam int          SR_FIFO_ERR  = 4;
  localparam int          SR_BUF_DONE  = 3;
  localparam int          SR_LAST_DONE = 2;
  localparam int          SR_AT_LAST   = 1;
  localparam int          SR_HALTED    = 0;
  localparam logic [4:0]  LAST_IDX_RST = 5'h00;
  localparam logic [4:0]  CUR_IDX_RST  = 5'h00;
  localparam logic [15:0] STATUS_RST   = 16'h0001;
  localparam logic [15:0] DWORDS_RST   = 16'h0000;
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_WORD      = 2'h1;
  localparam logic [1:0]  SZ_DWORD     = 2'h2;
  localparam int          FIFO_W       = 32;
  localparam int          FIFO_AW      = 3;
  localparam int          FIFO_DEPTH   = 8;
endpackage : abm_pkg

// ==== abm_sfifo.sv ====
/*
 Sample FIFO of one channel, memory with registered read data.
 Assumes callers use full/empty; a push when full is dropped and a pop
 when empty leaves the previous sample on the read port.
*/
`timescale 1ns/1ps
module abm_sfifo (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      push_i,
  input  wire logic [abm_pkg::FIFO_W-1:0] wdata_i,
  input  wire logic                      pop_i,
  output logic      [abm_pkg::FIFO_W-1:0] rdata_o,
  output logic                           full_o,
  output logic                           empty_o
);
  logic [abm_pkg::FIFO_W-1:0]  mem [abm_pkg::FIFO_DEPTH];
  logic [abm_pkg::FIFO_AW-1:0] wptr_reg;
  logic [abm_pkg::FIFO_AW-1:0] rptr_reg;
  logic [abm_pkg::FIFO_AW:0]   cnt_reg;
  logic [abm_pkg::FIFO_AW:0]   cnt_next;
  logic                        push_ok;
  logic                        pop_ok;

  // Overrun: pointers hold and the sample is lost
  assign push_ok = push_i && !full_o; // RULE_07
  assign pop_ok  = pop_i && !empty_o;

  always_comb begin
    cnt_next = cnt_reg;
    if (push_ok && !pop_ok) begin
      cnt_next = cnt_reg + 4'h1;
    end else if (pop_ok && !push_ok) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push_ok) begin
      mem[wptr_reg] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      cnt_reg  <= 4'h0;
      full_o   <= 1'b0;
      empty_o  <= 1'b1;
    end else if (ce_i) begin
      if (push_ok) begin
        wptr_reg <= wptr_reg + 3'h1;
      end
      if (pop_ok) begin
        rptr_reg <= rptr_reg + 3'h1;
      end
      cnt_reg <= cnt_next;
      full_o  <= (cnt_next == 4'h8);
      empty_o <= (cnt_next == 4'h0);
    end
  end

  // Under-run keeps the last valid sample on the port for replay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i && pop_ok) begin // RULE_08
      rdata_o <= mem[rptr_reg];
    end
  end
endmodule : abm_sfifo

// ==== abm_pos.sv ====
/*
 Count of DWords left in the current buffer of one channel.
 Assumes one dec_i pulse per DWord moved on the memory side.
*/
`timescale 1ns/1ps
module abm_pos (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        load_i,
  input  wire logic [15:0] len_i,
  input  wire logic        dec_i,
  output logic      [15:0] count_o,
  output logic             done_o
);
  // Final DWord of the buffer is moved in this cycle
  assign done_o = ce_i && dec_i && !load_i && (count_o == 16'h0001);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= abm_pkg::DWORDS_RST;
    end else if (ce_i) begin
      if (load_i) begin
        count_o <= len_i;
      end else if (dec_i && count_o != 16'h0000) begin // RULE_17
        count_o <= count_o - 16'h0001; // RULE_16
      end
    end
  end
endmodule : abm_pos

// ==== abm_channel_status.sv ====
/*
 Status and progress of the three audio bus-master channels (PCM in,
 PCM out, mic in): last valid index, current index, status flags,
 DWords left in the buffer, plus each channel's sample FIFO.
 Assumes an I/O port with byte addresses 00h-2Fh, accesses of 8, 16 or
 32 bits naturally aligned, data in the low lanes; a DMA engine that
 loads descriptors and reports every DWord moved to or from memory.
*/
// Function
// RULE_01: Last valid index is 5 bits; bits 7:5 read zero.
// RULE_02: Software rewrites last valid index whenever it appends a buffer.
// RULE_03: 32-bit read at 04h gives indices and status; byte at 05h gives it.
// RULE_04: Status is readable alone by a 16-bit read at 06h.
// RULE_05: Status resets to 0001h; bits 15:5 are reserved and read zero.
// RULE_06: FIFO error bit 4 sets on under/overrun while more buffers remain.
// RULE_07: Receive overrun holds FIFO pointers and drops the arriving sample.
// RULE_08: Transmit under-run resends the most recent valid sample.
// RULE_09: Event flags clear only by writing one; zero leaves them.
// RULE_10: Buffer done bit 3 sets after last sample if descriptor asks.
// RULE_11: Last buffer bit 2 sets and raises enabled interrupt until cleared.
// RULE_12: Transmit sets it on fetch; receive after data reaches memory.
// RULE_13: Bit 1 holds while current equals last and that buffer is done.
// RULE_14: Bit 1 clears itself when a new last valid index is written.
// RULE_15: Bit 0 shows halt by run bit cleared or last buffer finished.
// RULE_16: Position counts DWords of current buffer not yet moved in memory.
// RULE_17: Position ignores how many samples crossed the codec link.
// RULE_18: Three channel copies, sixteen bytes apart: 05h, 15h, 25h.
// RULE_19: Current index advances per descriptor and wraps after 31.
// RULE_20: Descriptor list holds 32 entries; indices are modulo 32.
// RULE_21: Run bit starts transfers; clearing it pauses keeping state.
// RULE_22: Last buffer interrupt enable gates only the interrupt.
// RULE_23: Stop fetching after last buffer; resume at next on new index. The code advances the index only if the run bit is set at that write.
`timescale 1ns/1ps
module abm_channel_status (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic [1:0]  io_size_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [31:0] io_wdata_i,
  output logic      [31:0] io_rdata_o,
  output logic             io_rvalid_o,
  input  wire logic [2:0]  run_i,
  input  wire logic [2:0]  last_irq_en_i,
  input  wire logic [2:0]  desc_load_i,
  input  wire logic [47:0] desc_len_i,
  input  wire logic [2:0]  desc_ioc_i,
  input  wire logic [2:0]  mem_dword_i,
  input  wire logic [2:0]  fifo_push_i,
  input  wire logic [95:0] fifo_wdata_i,
  input  wire logic [2:0]  fifo_pop_i,
  output logic      [95:0] fifo_rdata_o,
  output logic      [2:0]  fifo_full_o,
  output logic      [2:0]  fifo_empty_o,
  output logic      [2:0]  fetch_en_o,
  output logic      [2:0]  last_irq_o
);
  logic [4:0]  civ_reg  [abm_pkg::CH_COUNT];
  logic [4:0]  lvi_reg  [abm_pkg::CH_COUNT];
  logic [15:0] sr_val   [abm_pkg::CH_COUNT];
  logic [15:0] pos_val  [abm_pkg::CH_COUNT];
  logic [3:0]  io_off;
  logic [1:0]  io_ch;
  logic [31:0] rd_word;

  assign io_off = io_addr_i[3:0];
  assign io_ch  = io_addr_i[5:4];

  // Number of bytes covered by an access of the given size
  function automatic logic [2:0] acc_len(input logic [1:0] sz);
    unique case (sz)
      abm_pkg::SZ_BYTE:  acc_len = 3'h1;
      abm_pkg::SZ_WORD:  acc_len = 3'h2;
      abm_pkg::SZ_DWORD: acc_len = 3'h4;
      default:           acc_len = 3'h0;
    endcase
  endfunction : acc_len

  // True when byte offset t lies inside the access at base of size sz
  function automatic logic acc_hit(input logic [3:0] base,
                                   input logic [1:0] sz,
                                   input logic [3:0] t);
    logic [4:0] top;
    top     = {1'b0, base} + {2'h0, acc_len(sz)};
    acc_hit = (t >= base) && ({1'b0, t} < top);
  endfunction : acc_hit

  // Write data byte that lands on offset t
  function automatic logic [7:0] wr_byte(input logic [3:0]  base,
                                         input logic [3:0]  t,
                                         input logic [31:0] d);
    logic [1:0] lane;
    lane    = 2'(t - base);
    wr_byte = d[8*lane +: 8];
  endfunction : wr_byte

  genvar g;
  generate
    for (g = 0; g < abm_pkg::CH_COUNT; g++) begin : g_ch
      localparam bit IS_TX = (g == abm_pkg::TX_CH);
      logic       sel_wr;
      logic       lvi_we;
      logic [7:0] lvi_byte;
      logic [7:0] clr_byte;
      logic       sr_we;
      logic       buf_done;
      logic       last_done;
      logic       last_evt;
      logic       more_valid;
      logic       err_evt;
      logic       resume;
      logic       current_at_last_state_next;
      logic       lb_next;
      logic       ioc_reg;
      logic       fe_reg;
      logic       bd_reg;
      logic       lb_reg;
      logic       current_at_last_state_reg;
      logic       halt_reg;
      logic       fifo_full;
      logic       fifo_empty;

      // Channel blocks repeat every sixteen bytes
      assign sel_wr   = io_wr_i && (io_ch == 2'(g)); // RULE_18
      assign lvi_we   = sel_wr &&
                        acc_hit(io_off, io_size_i, abm_pkg::OFF_LAST_IDX);
      assign lvi_byte = wr_byte(io_off, abm_pkg::OFF_LAST_IDX, io_wdata_i);
      assign sr_we    = sel_wr &&
                        acc_hit(io_off, io_size_i, abm_pkg::OFF_STATUS);
      assign clr_byte = sr_we ?
                        wr_byte(io_off, abm_pkg::OFF_STATUS, io_wdata_i) :
                        8'h00;

      assign more_valid = (civ_reg[g] != lvi_reg[g]);
      assign last_done  = buf_done && !more_valid;
      // Transmit marks the last buffer when fetched, receive when written
      assign last_evt   = IS_TX ? (ce_i && desc_load_i[g] && !more_valid)
                                : last_done; // RULE_12
      // Only the direction's own hazard counts: overrun in, under-run out
      assign err_evt    = ce_i && more_valid &&
                          (IS_TX ? (fifo_pop_i[g] && fifo_empty)
                                 : (fifo_push_i[g] && fifo_full)); // RULE_06
      // Software moved the last index while the running channel sat at the end
      assign resume     = lvi_we && current_at_last_state_reg && run_i[g]; // RULE_23

      // Set wins over a clear arriving in the same cycle
      assign current_at_last_state_next = last_done || (current_at_last_state_reg && !lvi_we); // RULE_13
      assign lb_next   = last_evt ||
                         (lb_reg && !clr_byte[abm_pkg::SR_LAST_DONE]);

      abm_pos u_pos (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .load_i  (desc_load_i[g]),
        .len_i   (desc_len_i[16*g +: 16]),
        .dec_i   (mem_dword_i[g]),
        .count_o (pos_val[g]),
        .done_o  (buf_done)
      );

      abm_sfifo u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .push_i  (fifo_push_i[g]),
        .wdata_i (fifo_wdata_i[32*g +: 32]),
        .pop_i   (fifo_pop_i[g]),
        .rdata_o (fifo_rdata_o[32*g +: 32]),
        .full_o  (fifo_full),
        .empty_o (fifo_empty)
      );

      assign fifo_full_o[g]  = fifo_full;
      assign fifo_empty_o[g] = fifo_empty;

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          lvi_reg[g] <= abm_pkg::LAST_IDX_RST;
        end else if (ce_i && lvi_we) begin
          lvi_reg[g] <= lvi_byte[4:0]; // RULE_01
        end
      end

      // Index is 5 bits, so the increment wraps from 31 to 0
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          civ_reg[g] <= abm_pkg::CUR_IDX_RST;
        end else if (ce_i) begin
          if (resume || (buf_done && more_valid)) begin
            civ_reg[g] <= civ_reg[g] + 5'h01; // RULE_19 RULE_20
          end
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ioc_reg <= 1'b0;
        end else if (ce_i && desc_load_i[g]) begin
          ioc_reg <= desc_ioc_i[g];
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fe_reg <= abm_pkg::STATUS_RST[abm_pkg::SR_FIFO_ERR];
          bd_reg <= abm_pkg::STATUS_RST[abm_pkg::SR_BUF_DONE];
          lb_reg <= abm_pkg::STATUS_RST[abm_pkg::SR_LAST_DONE];
        end else if (ce_i) begin
          fe_reg <= err_evt ||
                    (fe_reg && !clr_byte[abm_pkg::SR_FIFO_ERR]); // RULE_09
          bd_reg <= (buf_done && ioc_reg) ||
                    (bd_reg && !clr_byte[abm_pkg::SR_BUF_DONE]); // RULE_10
          lb_reg <= lb_next; // RULE_11
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          current_at_last_state_reg <= abm_pkg::STATUS_RST[abm_pkg::SR_AT_LAST];
          halt_reg <= abm_pkg::STATUS_RST[abm_pkg::SR_HALTED];
        end else if (ce_i) begin
          current_at_last_state_reg <= current_at_last_state_next; // RULE_14
          // Paused channels keep every index and count intact
          halt_reg <= !run_i[g] || current_at_last_state_next; // RULE_15 RULE_21
        end
      end

      // Interrupt follows the flag, so clearing the flag drops it
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fetch_en_o[g] <= 1'b0;
          last_irq_o[g] <= 1'b0;
        end else if (ce_i) begin
          fetch_en_o[g] <= run_i[g] && !current_at_last_state_next; // RULE_23 RULE_21
          last_irq_o[g] <= lb_next && last_irq_en_i[g]; // RULE_22 RULE_11
        end
      end

      assign sr_val[g] = {11'h000, fe_reg, bd_reg, lb_reg,
                          current_at_last_state_reg, halt_reg}; // RULE_05
    end
  endgenerate

  // Byte image of one channel block; unlisted offsets read zero
  function automatic logic [7:0] img_byte(input logic [4:0]  current_descriptor_index,
                                          input logic [4:0]  last_valid_index,
                                          input logic [15:0] sr,
                                          input logic [15:0] pos,
                                          input logic [3:0]  t);
    unique case (t)
      abm_pkg::OFF_CUR_IDX:        img_byte = {3'h0, current_descriptor_index};
      abm_pkg::OFF_LAST_IDX:       img_byte = {3'h0, last_valid_index}; // RULE_01
      abm_pkg::OFF_STATUS:         img_byte = sr[7:0];
      abm_pkg::OFF_STATUS + 4'h1:  img_byte = sr[15:8];
      abm_pkg::OFF_DWORDS:         img_byte = pos[7:0];
      abm_pkg::OFF_DWORDS + 4'h1:  img_byte = pos[15:8];
      default:                     img_byte = 8'h00;
    endcase
  endfunction : img_byte

  // Each lane reads the byte at its own offset, so 32 bits at 04h give
  // both indices and status, 8 bits at 05h the last index alone
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (io_ch != 2'h3 && 3'(k) < acc_len(io_size_i)) begin
        rd_word[8*k +: 8] = img_byte(civ_reg[io_ch], lvi_reg[io_ch],
                                     sr_val[io_ch], pos_val[io_ch],
                                     4'(io_off + 4'(k))); // RULE_03 RULE_04
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_rdata_o  <= 32'h0000_0000;
      io_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      io_rvalid_o <= io_rd_i;
      if (io_rd_i) begin
        io_rdata_o <= rd_word;
      end
    end
  end
endmodule : abm_channel_status

// ==== abm_channel_status_chk.sv ====
/*
 Port-level assertions for the audio bus-master channel status block.
 Assumes one clock, async active-low reset, bound to the top module.
*/
`timescale 1ns/1ps
module abm_channel_status_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [5:0]  io_addr_i,
  input wire logic [1:0]  io_size_i,
  input wire logic        io_rd_i,
  input wire logic        io_wr_i,
  input wire logic [31:0] io_wdata_i,
  input wire logic [31:0] io_rdata_o,
  input wire logic        io_rvalid_o,
  input wire logic [2:0]  run_i,
  input wire logic [2:0]  last_irq_en_i,
  input wire logic [2:0]  mem_dword_i,
  input wire logic [2:0]  fifo_push_i,
  input wire logic [2:0]  fifo_pop_i,
  input wire logic [95:0] fifo_rdata_o,
  input wire logic [2:0]  fifo_full_o,
  input wire logic [2:0]  fifo_empty_o,
  input wire logic [2:0]  fetch_en_o,
  input wire logic [2:0]  last_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rv; ce_i && io_rd_i |=> io_rvalid_o; endproperty
  a_rv: assert property (p_rv)
    else $error("read answer missing");
  property p_rv1; ce_i && !io_rd_i |=> !io_rvalid_o; endproperty
  a_rv1: assert property (p_rv1)
    else $error("read answer without read");
  property p_lvi;
    ce_i && io_rd_i && io_addr_i[3:0] == 4'h5 && io_size_i == 2'h0
    |=> io_rdata_o[31:5] == 27'h0;
  endproperty
  a_lvi: assert property (p_lvi)
    else $error("index byte upper bits set");
  property p_sr;
    ce_i && io_rd_i && io_addr_i[3:0] == 4'h6 && io_size_i == 2'h1
    |=> io_rdata_o[31:5] == 27'h0;
  endproperty
  a_sr: assert property (p_sr)
    else $error("reserved status bits set");
  property p_ch3; ce_i && io_rd_i && io_addr_i[5:4] == 2'h3
    |=> io_rdata_o == 32'h0; endproperty
  a_ch3: assert property (p_ch3)
    else $error("read beyond channels not zero");
  property p_irq; (last_irq_o & ~$past(last_irq_en_i)) == 3'h0; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt while disabled");
  property p_irqc;
    ce_i && io_wr_i && io_addr_i == 6'h06 && io_size_i == 2'h1 &&
    io_wdata_i[2] && !mem_dword_i[0] |=> !last_irq_o[0];
  endproperty
  a_irqc: assert property (p_irqc)
    else $error("interrupt kept after clear");
  property p_fet; (fetch_en_o & ~$past(run_i)) == 3'h0; endproperty
  a_fet: assert property (p_fet)
    else $error("fetch while paused");
  property p_ovr; ce_i && fifo_full_o[0] && fifo_push_i[0] &&
    !fifo_pop_i[0] |=> fifo_full_o[0]; endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun moved pointers");
  property p_und; ce_i && fifo_empty_o[1] && fifo_pop_i[1] &&
    !fifo_push_i[1] |=> $stable(fifo_rdata_o[63:32]); endproperty
  a_und: assert property (p_und)
    else $error("underrun changed sample");
endmodule : abm_channel_status_chk
bind abm_channel_status abm_channel_status_chk u_chk (.clk_i, .rst_n_i,
  .ce_i, .io_addr_i, .io_size_i, .io_rd_i, .io_wr_i, .io_wdata_i,
  .io_rdata_o, .io_rvalid_o, .run_i, .last_irq_en_i, .mem_dword_i,
  .fifo_push_i, .fifo_pop_i, .fifo_rdata_o, .fifo_full_o, .fifo_empty_o,
  .fetch_en_o, .last_irq_o);

// ==== abm_dma_model.sv ====
/*
 Memory-side partner: loads one descriptor, then moves its DWords.
 Assumes the bench starts one buffer at a time; hold_i stalls it.
*/
`timescale 1ns/1ps
module abm_dma_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  go_i,
  input  wire logic [15:0] len_i,
  input  wire logic        ioc_i,
  input  wire logic        hold_i,
  output logic      [2:0]  desc_load_o,
  output logic      [47:0] desc_len_o,
  output logic      [2:0]  desc_ioc_o,
  output logic      [2:0]  mem_dword_o,
  output logic             busy_o
);
  logic [2:0]  ch_reg;
  logic [15:0] left_reg;
  assign busy_o = (left_reg != 16'h0) || (mem_dword_o != 3'h0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      desc_load_o <= 3'h0;
      desc_len_o  <= 48'h0;
      desc_ioc_o  <= 3'h0;
      mem_dword_o <= 3'h0;
      ch_reg      <= 3'h0;
      left_reg    <= 16'h0;
    end else begin
      desc_load_o <= go_i;
      mem_dword_o <= 3'h0;
      if (go_i != 3'h0) begin
        ch_reg     <= go_i;
        left_reg   <= len_i;
        desc_len_o <= {3{len_i}};
        desc_ioc_o <= {3{ioc_i}};
      end else begin
        // Length and flag mean nothing outside a load
        desc_len_o <= ~desc_len_o;
        desc_ioc_o <= ~desc_ioc_o;
        if (left_reg != 16'h0 && !hold_i) begin
          mem_dword_o <= ch_reg;
          left_reg    <= left_reg - 16'h1;
        end
      end
    end
  end
endmodule : abm_dma_model

// ==== abm_channel_status_bench.sv ====
/*
 Self-checking bench for the channel status block and its DMA partner.
 Assumes the design and checker files are compiled before this one.
*/
`timescale 1ns/1ps
module abm_channel_status_bench;
  logic clk_i, rst_n_i, ce_i, io_rd_i, io_wr_i, io_rvalid_o, interrupt_on_completion, hold, busy;
  logic [5:0]  io_addr_i;
  logic [1:0]  io_size_i;
  logic [31:0] io_wdata_i, io_rdata_o;
  logic [2:0]  run_i, last_irq_en_i, desc_load_i, desc_ioc_i, mem_dword_i;
  logic [2:0]  fifo_push_i, fifo_pop_i, fifo_full_o, fifo_empty_o, go;
  logic [2:0]  fetch_en_o, last_irq_o;
  logic [47:0] desc_len_i;
  logic [95:0] fifo_wdata_i, fifo_rdata_o;
  logic [15:0] len;
  int          err_total, checked;
  abm_channel_status dut (.clk_i, .rst_n_i, .ce_i, .io_addr_i, .io_size_i,
    .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .run_i,
    .last_irq_en_i, .desc_load_i, .desc_len_i, .desc_ioc_i, .mem_dword_i,
    .fifo_push_i, .fifo_wdata_i, .fifo_pop_i, .fifo_rdata_o, .fifo_full_o,
    .fifo_empty_o, .fetch_en_o, .last_irq_o);
  abm_dma_model u_dma (.clk_i, .rst_n_i, .go_i(go), .len_i(len),
    .ioc_i(interrupt_on_completion), .hold_i(hold), .desc_load_o(desc_load_i),
    .desc_len_o(desc_len_i), .desc_ioc_o(desc_ioc_i),
    .mem_dword_o(mem_dword_i), .busy_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [5:0] a, input logic [1:0] s,
                    input logic [31:0] e);
    @(negedge clk_i);
    io_addr_i = a;
    io_size_i = s;
    io_rd_i = 1'b1;
    // The valid strobe stands only in the cycle after the taking edge; the data holds until the next read
    @(negedge clk_i);
    chk({31'h0, io_rvalid_o}, 32'h1);
    chk(io_rdata_o, e);
    io_rd_i = 1'b0;
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [1:0] s,
                    input logic [31:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_size_i = s;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
  endtask : wr
  task automatic push(input int g, input logic [31:0] d);
    @(negedge clk_i);
    fifo_wdata_i[32*g+:32] = d;
    fifo_push_i[g] = 1'b1;
    @(negedge clk_i);
    fifo_push_i[g] = 1'b0;
  endtask : push
  task automatic pop(input int g, input logic [31:0] e);
    @(negedge clk_i);
    fifo_pop_i[g] = 1'b1;
    @(negedge clk_i);
    fifo_pop_i[g] = 1'b0;
    chk(fifo_rdata_o[32*g+:32], e);
  endtask : pop
  task automatic wt();
    for (int i = 0; i < 60 && busy; i++) @(negedge clk_i);
    // Let the flags of the final DWord settle before the next access
    repeat (2) @(negedge clk_i);
  endtask : wt
  task automatic dma(input logic [2:0] m, input logic [15:0] l,
                     input logic c);
    @(negedge clk_i);
    go = m;
    len = l;
    interrupt_on_completion = c;
    @(negedge clk_i);
    go = 3'h0;
    wt();
  endtask : dma
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  initial begin
    {rst_n_i, io_rd_i, io_wr_i, interrupt_on_completion, hold, io_addr_i, io_size_i} = '0;
    {io_wdata_i, run_i, fifo_push_i, fifo_pop_i, go, len} = '0;
    fifo_wdata_i = '0;
    ce_i = 1'b1;
    last_irq_en_i = 3'b001;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int g = 0; g < 3; g++) begin
      rd({g[1:0], 4'h4}, 2'h2, 32'h0001_0000);
      rd({g[1:0], 4'h8}, 2'h1, 32'h0);
    end
    rd(6'h30, 2'h2, 32'h0);
    rd(6'h0c, 2'h2, 32'h0);
    wr(6'h05, 2'h0, 32'hff);
    rd(6'h05, 2'h0, 32'h1f);
    rd(6'h15, 2'h0, 32'h0);
    run_i = 3'b111;
    rd(6'h26, 2'h1, 32'h0);
    chk(fetch_en_o, 3'b111);
    run_i = 3'b011;
    rd(6'h26, 2'h1, 32'h1);
    for (int i = 0; i < 9; i++) push(0, i);
    chk(fifo_full_o[0], 1'b1);
    rd(6'h06, 2'h1, 32'h10);
    for (int i = 0; i < 8; i++) pop(0, i);
    chk(fifo_empty_o[0], 1'b1);
    wr(6'h06, 2'h1, 32'h0);
    rd(6'h06, 2'h1, 32'h10);
    wr(6'h06, 2'h1, 32'h10);
    rd(6'h06, 2'h1, 32'h0);
    wr(6'h05, 2'h0, 32'h1);
    dma(3'b001, 16'h3, 1'b1);
    rd(6'h04, 2'h2, 32'h0008_0101);
    wr(6'h06, 2'h1, 32'h8);
    dma(3'b001, 16'h2, 1'b0);
    rd(6'h04, 2'h2, 32'h0007_0101);
    chk(last_irq_o[0], 1'b1);
    chk(fetch_en_o[0], 1'b0);
    wr(6'h06, 2'h1, 32'h4);
    chk(last_irq_o[0], 1'b0);
    rd(6'h06, 2'h1, 32'h3);
    wr(6'h05, 2'h0, 32'h2);
    rd(6'h04, 2'h2, 32'h0000_0202);
    chk(fetch_en_o[0], 1'b1);
    hold = 1'b1;
    dma(3'b010, 16'h1, 1'b0);
    rd(6'h16, 2'h1, 32'h4);
    rd(6'h18, 2'h1, 32'h1);
    push(1, 32'ha5);
    pop(1, 32'ha5);
    pop(1, 32'ha5);
    rd(6'h18, 2'h1, 32'h1);
    hold = 1'b0;
    wt();
    rd(6'h14, 2'h2, 32'h0007_0000);
    chk(last_irq_o, 3'b000);
    // A write with the clock enable low must leave the register alone
    ce_i = 1'b0;
    wr(6'h05, 2'h0, 32'h3);
    ce_i = 1'b1;
    rd(6'h05, 2'h0, 32'h2);
    end_of_test();
  end
endmodule : abm_channel_status_bench
